// [core/smbus_seq_pkg.sv]
// package: register map, field positions, timing and types of the transfer sequencer
package smbus_seq_pkg;
   // register byte offsets on the AHB-Lite bus
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] DATA_ADDR = 8'h08;
   localparam logic [7:0] SLAVE_ADDR_ADDR = 8'h0C;
   localparam logic [7:0] MASK_ADDR = 8'h10;
   // control register bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_ACK = 2;
   localparam int CTRL_HWACK = 3;
   localparam int CTRL_INHIBIT = 4;
   localparam int CTRL_DONE = 5;
   // status register bit positions
   localparam int STAT_DONE = 0;
   localparam int STAT_ACK_REQUEST_FLAG = 1;
   localparam int STAT_MASTER = 2;
   localparam int STAT_TX = 3;
   localparam int STAT_ACKRX = 4;
   localparam int STAT_ERROR = 5;
   localparam int STAT_BUSY = 6;
   // reset values
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [6:0] SLAVE_ADDR_RESET = 7'h00;
   localparam logic [6:0] MASK_RESET = 7'h7F;
   // timing: half period of the generated serial clock
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCL_HALF_NS = 5000;
   localparam int SCL_HALF_CYCLES = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] HALF_LAST = 8'(SCL_HALF_CYCLES - 1);
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   typedef enum logic [6:0] {
      IDLE = 7'b0000001,
      START_GEN = 7'b0000010,
      STOP_GEN = 7'b0000100,
      BIT_LOW = 7'b0001000,
      MASTER_HIGH = 7'b0010000,
      SLAVE_BIT = 7'b0100000,
      HOLD = 7'b1000000
   } phase_type;

   typedef struct packed {
      logic startReq;
      logic stopReq;
      logic ackBit;
      logic hwAck;
      logic inhibit;
   } ctrl_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_type;

   typedef struct packed {
      phase_type phase;
      logic [1:0] sub;
      logic [7:0] count;
      line_type sync1;
      line_type sync2;
      line_type prev;
      logic sclOe;
      logic sdaOe;
      ctrl_type ctrl;
      logic byteDone;
      logic ackRequest;
      logic preAck;
      logic master;
      logic txMode;
      logic ackReceived;
      logic error;
      logic slaveIgnore;
      logic addrPhase;
      logic dataWritten;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [6:0] slaveAddr;
      logic [6:0] addrMask;
      logic hselD;
      logic hwriteD;
      logic [7:0] addrD;
      logic [31:0] hrdata;
      logic hreadyout;
   } state_type;
endpackage : smbus_seq_pkg

// [core/smbus_transfer_sequencer.sv]
// byte-level master/slave transfer sequencer for a two-wire serial bus with AHB-Lite registers
// Operation
// - master write: START, address with direction 0, data bytes acked by slave
// - stop request bit makes the master drive STOP and end the transfer
// - master transmitter becomes receiver when flag cleared without data write
// - transmitter byte interrupts come after the acknowledge cycle
// - master read: START, address with direction 1, master clocks in bytes
// - hardware ack off: set ack request and interrupt before the ACK
// - hardware ack on: drive ACK from preloaded bit, then interrupt
// - acknowledge bit 1 sends ACK, 0 sends NACK
// - master mode left only after stop request and generated STOP
// - data write while active master receiver switches to transmitter
// - with slave inhibit 0, START plus address enters slave receiver
// - hardware ack off: address interrupts with ack request, software decides
// - hardware ack on: ack addresses matching address and mask, interrupt after
// - rejected address suppresses slave interrupts until next START
// - slave receiver left on received STOP
// - data write while active slave receiver switches to transmitter
// - after read address ack, software loads data, slave shifts it out
// - data write after master NACK of slave byte flags an error
// - slave transmitter left on received STOP
// - slave transmitter becomes receiver when flag cleared without data write
// - shift MSB first, capturing bus bits while transmitting
`timescale 1ns/1ps
module smbus_transfer_sequencer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);
   smbus_seq_pkg::state_type r_reg;
   smbus_seq_pkg::state_type r_next;
   logic startSeen;
   logic stopSeen;
   logic sclRise;
   logic sclFall;
   logic clearReq;
   logic halfDone;
   logic ackGo;
   logic sampleNow;
   logic advance;
   logic busTake;
   logic outLow;

   function automatic logic addrMatch(input logic [7:0] rx, input logic [6:0] adr,
                                      input logic [6:0] msk);
      addrMatch = (((rx[7:1] ^ adr) & msk) == 7'h00);
   endfunction : addrMatch

   always_comb begin
      r_next = r_reg;
      ackGo = 1'b0;
      sampleNow = 1'b0;
      advance = 1'b0;
      clearReq = 1'b0;
      outLow = 1'b0;
      // pin synchronisers and bus condition detection
      r_next.sync1.scl = sclIn;
      r_next.sync1.sda = sdaIn;
      r_next.sync2 = r_reg.sync1;
      r_next.prev = r_reg.sync2;
      sclRise = r_reg.sync2.scl & ~r_reg.prev.scl;
      sclFall = ~r_reg.sync2.scl & r_reg.prev.scl;
      startSeen = r_reg.sync2.scl & r_reg.prev.scl & r_reg.prev.sda & ~r_reg.sync2.sda;
      stopSeen = r_reg.sync2.scl & r_reg.prev.scl & ~r_reg.prev.sda & r_reg.sync2.sda;
      halfDone = (r_reg.count == smbus_seq_pkg::HALF_LAST);

      // AHB-Lite address phase: capture, and prepare read data for the data phase
      busTake = hsel & htrans[1] & hready;
      r_next.hselD = busTake;
      r_next.hwriteD = hwrite;
      r_next.addrD = haddr[7:0];
      r_next.hreadyout = 1'b1;
      if (busTake && !hwrite) begin
         r_next.hrdata = 32'h0000_0000;
         unique case (haddr[7:0])
            smbus_seq_pkg::CTRL_ADDR: begin
               r_next.hrdata[smbus_seq_pkg::CTRL_START] = r_reg.ctrl.startReq;
               r_next.hrdata[smbus_seq_pkg::CTRL_STOP] = r_reg.ctrl.stopReq;
               r_next.hrdata[smbus_seq_pkg::CTRL_ACK] = r_reg.ctrl.ackBit;
               r_next.hrdata[smbus_seq_pkg::CTRL_HWACK] = r_reg.ctrl.hwAck;
               r_next.hrdata[smbus_seq_pkg::CTRL_INHIBIT] = r_reg.ctrl.inhibit;
               r_next.hrdata[smbus_seq_pkg::CTRL_DONE] = r_reg.byteDone;
            end
            smbus_seq_pkg::STATUS_ADDR: begin
               r_next.hrdata[smbus_seq_pkg::STAT_DONE] = r_reg.byteDone;
               r_next.hrdata[smbus_seq_pkg::STAT_ACK_REQUEST_FLAG] = r_reg.ackRequest;
               r_next.hrdata[smbus_seq_pkg::STAT_MASTER] = r_reg.master;
               r_next.hrdata[smbus_seq_pkg::STAT_TX] = r_reg.txMode;
               r_next.hrdata[smbus_seq_pkg::STAT_ACKRX] = r_reg.ackReceived;
               r_next.hrdata[smbus_seq_pkg::STAT_ERROR] = r_reg.error;
               r_next.hrdata[smbus_seq_pkg::STAT_BUSY] = (r_reg.phase != smbus_seq_pkg::IDLE);
            end
            smbus_seq_pkg::DATA_ADDR: r_next.hrdata[7:0] = r_reg.shift;
            smbus_seq_pkg::SLAVE_ADDR_ADDR: r_next.hrdata[6:0] = r_reg.slaveAddr;
            smbus_seq_pkg::MASK_ADDR: r_next.hrdata[6:0] = r_reg.addrMask;
            default: r_next.hrdata = 32'h0000_0000;
         endcase
      end

      // AHB-Lite data phase: register writes
      if (r_reg.hselD && r_reg.hwriteD) begin
         unique case (r_reg.addrD)
            smbus_seq_pkg::CTRL_ADDR: begin
               r_next.ctrl.startReq = hwdata[smbus_seq_pkg::CTRL_START];
               r_next.ctrl.stopReq = hwdata[smbus_seq_pkg::CTRL_STOP];
               r_next.ctrl.ackBit = hwdata[smbus_seq_pkg::CTRL_ACK];
               r_next.ctrl.hwAck = hwdata[smbus_seq_pkg::CTRL_HWACK];
               r_next.ctrl.inhibit = hwdata[smbus_seq_pkg::CTRL_INHIBIT];
               clearReq = r_reg.byteDone & ~hwdata[smbus_seq_pkg::CTRL_DONE];
            end
            smbus_seq_pkg::STATUS_ADDR: begin
               if (hwdata[smbus_seq_pkg::STAT_ERROR]) begin
                  r_next.error = 1'b0;
               end
            end
            smbus_seq_pkg::DATA_ADDR: begin
               if (r_reg.byteDone) begin
                  r_next.shift = hwdata[7:0];
                  r_next.dataWritten = 1'b1;
               end
            end
            smbus_seq_pkg::SLAVE_ADDR_ADDR: r_next.slaveAddr = hwdata[6:0];
            smbus_seq_pkg::MASK_ADDR: r_next.addrMask = hwdata[6:0];
            default: r_next.ctrl = r_reg.ctrl;
         endcase
      end

      // transfer engine
      r_next.count = r_reg.count + 8'h01;
      unique case (r_reg.phase)
         smbus_seq_pkg::IDLE: begin
            r_next.count = 8'h00;
            if (r_reg.ctrl.startReq) begin
               r_next.phase = smbus_seq_pkg::START_GEN;
               r_next.sub = 2'h0;
               r_next.master = 1'b1;
            end
         end
         smbus_seq_pkg::START_GEN: begin
            r_next.sdaOe = (r_reg.sub == 2'h1);
            r_next.sclOe = 1'b0;
            if (r_reg.sub == 2'h0 && !r_reg.sync2.scl) begin
               r_next.count = 8'h00;
            end else if (halfDone && r_reg.sub == 2'h0) begin
               r_next.sub = 2'h1;
               r_next.count = 8'h00;
            end else if (halfDone) begin
               r_next.sclOe = 1'b1;
               r_next.phase = smbus_seq_pkg::HOLD;
               r_next.byteDone = 1'b1;
               r_next.txMode = 1'b1;
               r_next.ctrl.startReq = 1'b0;
               r_next.bitCnt = 4'h0;
               r_next.preAck = 1'b0;
               r_next.ackRequest = 1'b0;
               r_next.addrPhase = 1'b0;
            end
         end
         smbus_seq_pkg::STOP_GEN: begin
            r_next.sclOe = (r_reg.sub == 2'h0);
            r_next.sdaOe = (r_reg.sub != 2'h2);
            if (r_reg.sub == 2'h1 && !r_reg.sync2.scl) begin
               r_next.count = 8'h00;
            end else if (halfDone && r_reg.sub != 2'h2) begin
               r_next.sub = r_reg.sub + 2'h1;
               r_next.count = 8'h00;
            end else if (halfDone) begin
               r_next.phase = smbus_seq_pkg::IDLE;
               r_next.master = 1'b0;
               r_next.txMode = 1'b0;
               r_next.ctrl.stopReq = 1'b0;
            end
         end
         smbus_seq_pkg::BIT_LOW: begin
            r_next.sclOe = 1'b1;
            if (halfDone) begin
               r_next.count = 8'h00;
               r_next.sclOe = 1'b0;
               r_next.phase = r_reg.master ? smbus_seq_pkg::MASTER_HIGH : smbus_seq_pkg::SLAVE_BIT;
            end
         end
         smbus_seq_pkg::MASTER_HIGH: begin
            if (!r_reg.sync2.scl) begin
               r_next.count = 8'h00;
            end else if (halfDone) begin
               sampleNow = 1'b1;
               advance = 1'b1;
               r_next.count = 8'h00;
               r_next.sclOe = 1'b1;
               r_next.phase = smbus_seq_pkg::BIT_LOW;
            end
         end
         smbus_seq_pkg::SLAVE_BIT: begin
            sampleNow = sclRise;
            advance = sclFall;
         end
         smbus_seq_pkg::HOLD: begin
            r_next.sclOe = 1'b1;
            r_next.count = 8'h00;
            if (clearReq) begin
               r_next.byteDone = 1'b0;
               r_next.ackRequest = 1'b0;
               r_next.dataWritten = 1'b0;
               r_next.phase = smbus_seq_pkg::BIT_LOW;
               if (r_reg.preAck) begin
                  r_next.preAck = 1'b0;
                  r_next.bitCnt = smbus_seq_pkg::ACK_SLOT;
                  // bits written together with the flag clear take effect at once
                  r_next.sdaOe = r_next.ctrl.ackBit;
                  r_next.slaveIgnore = r_reg.addrPhase & ~r_next.ctrl.ackBit;
               end else if (r_reg.master && r_next.ctrl.stopReq) begin
                  r_next.phase = smbus_seq_pkg::STOP_GEN;
                  r_next.sub = 2'h0;
               end else if (r_reg.master && r_next.ctrl.startReq) begin
                  r_next.phase = smbus_seq_pkg::START_GEN;
                  r_next.sub = 2'h0;
               end else begin
                  outLow = r_reg.dataWritten;
                  if (!r_reg.master && r_reg.txMode && !r_reg.ackReceived && r_reg.dataWritten) begin
                     r_next.error = 1'b1;
                     outLow = 1'b0;
                  end
                  r_next.txMode = outLow;
                  r_next.sdaOe = outLow & ~r_reg.shift[7];
               end
            end
         end
         default: r_next.phase = smbus_seq_pkg::IDLE;
      endcase

      if (sampleNow) begin
         if (r_reg.bitCnt < smbus_seq_pkg::ACK_SLOT) begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sync2.sda};
         end else begin
            r_next.ackReceived = ~r_reg.sync2.sda;
         end
      end

      if (advance) begin
         if (r_reg.bitCnt < smbus_seq_pkg::LAST_DATA_BIT) begin
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
            r_next.sdaOe = r_reg.txMode & ~r_next.shift[7];
         end else if (r_reg.bitCnt == smbus_seq_pkg::LAST_DATA_BIT) begin
            if (r_reg.txMode) begin
               r_next.sdaOe = 1'b0;
               r_next.bitCnt = smbus_seq_pkg::ACK_SLOT;
            end else if (r_reg.ctrl.hwAck) begin
               ackGo = r_reg.addrPhase ? addrMatch(r_next.shift, r_reg.slaveAddr, r_reg.addrMask)
                                       : r_reg.ctrl.ackBit;
               r_next.sdaOe = ackGo;
               r_next.bitCnt = smbus_seq_pkg::ACK_SLOT;
               r_next.slaveIgnore = r_reg.addrPhase & ~ackGo;
            end else begin
               r_next.byteDone = 1'b1;
               r_next.ackRequest = 1'b1;
               r_next.preAck = 1'b1;
               r_next.sdaOe = 1'b0;
               r_next.sclOe = 1'b1;
               r_next.phase = smbus_seq_pkg::HOLD;
            end
         end else begin
            r_next.sdaOe = 1'b0;
            r_next.bitCnt = 4'h0;
            r_next.addrPhase = 1'b0;
            if (r_reg.slaveIgnore) begin
               r_next.phase = smbus_seq_pkg::IDLE;
               r_next.sclOe = 1'b0;
            end else begin
               r_next.byteDone = 1'b1;
               r_next.ackRequest = 1'b0;
               r_next.sclOe = 1'b1;
               r_next.phase = smbus_seq_pkg::HOLD;
            end
         end
      end

      // remote START and STOP while not master
      if (!r_reg.master && startSeen) begin
         r_next.slaveIgnore = 1'b0;
         if (!r_reg.ctrl.inhibit) begin
            r_next.phase = smbus_seq_pkg::SLAVE_BIT;
            r_next.bitCnt = 4'h0;
            r_next.addrPhase = 1'b1;
            r_next.txMode = 1'b0;
            r_next.byteDone = 1'b0;
            r_next.ackRequest = 1'b0;
            r_next.preAck = 1'b0;
            r_next.sdaOe = 1'b0;
            r_next.sclOe = 1'b0;
         end
      end else if (!r_reg.master && stopSeen) begin
         r_next.phase = smbus_seq_pkg::IDLE;
         r_next.txMode = 1'b0;
         r_next.addrPhase = 1'b0;
         r_next.byteDone = 1'b0;
         r_next.ackRequest = 1'b0;
         r_next.preAck = 1'b0;
         r_next.sdaOe = 1'b0;
         r_next.sclOe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
         r_reg.phase <= smbus_seq_pkg::IDLE;
         r_reg.sync1 <= 2'b11;
         r_reg.sync2 <= 2'b11;
         r_reg.prev <= 2'b11;
         r_reg.shift <= smbus_seq_pkg::DATA_RESET;
         r_reg.slaveAddr <= smbus_seq_pkg::SLAVE_ADDR_RESET;
         r_reg.addrMask <= smbus_seq_pkg::MASK_RESET;
         r_reg.hreadyout <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign hrdata = r_reg.hrdata;
   assign hreadyout = r_reg.hreadyout;
   assign hresp = r_reg.addrPhase & 1'b0;
   assign sclOut = r_reg.sub[0] & 1'b0;
   assign sdaOut = r_reg.sub[1] & 1'b0;
   assign sclOe = r_reg.sclOe;
   assign sdaOe = r_reg.sdaOe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence startDriven;
      r_reg.phase == smbus_seq_pkg::START_GEN && r_reg.sub == 2'h1 && halfDone;
   endsequence
   sequence stopEntered;
      r_reg.phase == smbus_seq_pkg::HOLD && clearReq && !r_reg.preAck && r_reg.master
         && r_next.ctrl.stopReq;
   endsequence

   start_done_a: assert property (startDriven |=> r_reg.byteDone && r_reg.txMode
         && r_reg.master && r_reg.sclOe && r_reg.sdaOe)
      else $error("start did not end in held master transmitter");
   stop_ends_a: assert property (stopEntered |=> ##[1:1000] r_reg.phase == smbus_seq_pkg::IDLE
         && !r_reg.master && !r_reg.sdaOe && !r_reg.sclOe)
      else $error("stop sequence did not release the bus");
   master_kept_a: assert property (r_reg.master && r_reg.phase != smbus_seq_pkg::STOP_GEN
         |=> r_reg.master)
      else $error("master mode left without stop");
   mode_switch_a: assert property ($fell(r_reg.byteDone) && !$past(r_reg.preAck)
         && !$past(r_reg.ctrl.stopReq) && !$past(r_reg.ctrl.startReq)
         && ($past(r_reg.master) || $past(r_reg.ackReceived) || !$past(r_reg.txMode))
         && r_reg.phase == smbus_seq_pkg::BIT_LOW
         |-> r_reg.txMode == $past(r_reg.dataWritten))
      else $error("mode after flag clear does not follow data write");
   tx_after_ack_a: assert property ($rose(r_reg.byteDone) && r_reg.txMode && !r_reg.master
         |-> $past(r_reg.bitCnt) == smbus_seq_pkg::ACK_SLOT)
      else $error("transmitter interrupt before acknowledge cycle");
   rx_pre_ack_a: assert property ($rose(r_reg.byteDone) && !r_reg.txMode && !r_reg.ctrl.hwAck
         && $past(r_reg.bitCnt) == smbus_seq_pkg::LAST_DATA_BIT
         |-> r_reg.ackRequest && r_reg.preAck && r_reg.sclOe)
      else $error("receiver without hardware ack did not request ack");
   ack_value_a: assert property ($fell(r_reg.byteDone) && $past(r_reg.preAck)
         |-> r_reg.sdaOe == $past(r_next.ctrl.ackBit)
         && r_reg.bitCnt == smbus_seq_pkg::ACK_SLOT)
      else $error("acknowledge drive differs from ack bit");
   ignore_quiet_a: assert property (r_reg.slaveIgnore && !r_reg.master && !startSeen
         |=> !$rose(r_reg.byteDone))
      else $error("slave interrupt while address ignored");
   slave_stop_a: assert property (!r_reg.master && stopSeen && !startSeen
         |=> r_reg.phase == smbus_seq_pkg::IDLE && !r_reg.sclOe ##1 !r_reg.byteDone)
      else $error("slave did not leave on stop");
   hold_clock_a: assert property (r_reg.byteDone |-> r_reg.sclOe
         && r_reg.phase == smbus_seq_pkg::HOLD)
      else $error("clock not held while byte done");
endmodule : smbus_transfer_sequencer

// [sim/smbus_remote_slave.sv]
// remote slave model: acks its address and written bytes, returns a fixed byte on reads
`timescale 1ns/1ps
module smbus_remote_slave #(
   parameter logic [6:0] ADDR = 7'h5A,
   parameter logic [7:0] READ_BYTE = 8'hC3
) (
   input wire logic scl,
   input wire logic sda,
   output logic sdaLow,
   output logic [7:0] lastByte,
   output logic masterAcked,
   output logic stopSeen
);
   int bitNum = 0;
   logic [7:0] sh = 8'h00;
   logic addrPhase = 1'b0;
   logic reading = 1'b0;
   initial begin
      sdaLow = 1'b0;
      lastByte = 8'h00;
      masterAcked = 1'b0;
      stopSeen = 1'b0;
   end
   // start and stop seen as data edges while the clock is high
   // a data change in the same step as a clock fall is no bus condition
   always @(negedge sda) begin
      #1;
      if (scl === 1'b1) begin
         bitNum = 0;
         addrPhase = 1'b1;
         reading = 1'b0;
         stopSeen = 1'b0;
      end
   end
   always @(posedge sda) begin
      #1;
      if (scl === 1'b1) begin
         stopSeen = 1'b1;
         sdaLow = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (bitNum < 8) begin
         sh = {sh[6:0], sda};
      end else if (reading) begin
         masterAcked = ~sda;
         reading = ~sda;
      end
      bitNum++;
   end
   always @(negedge scl) begin
      if (bitNum == 8) begin
         lastByte = sh;
         if (addrPhase) begin
            sdaLow = (sh[7:1] == ADDR);
            reading = (sh[7:1] == ADDR) & sh[0];
            addrPhase = 1'b0;
         end else begin
            sdaLow = ~reading;
         end
      end else begin
         if (bitNum == 9) begin
            bitNum = 0;
         end
         sdaLow = reading & ~READ_BYTE[7 - bitNum];
      end
   end
endmodule : smbus_remote_slave

// [sim/tb.sv]
// testbench: register reset values and master write/read transfers
`timescale 1ns/1ps
module tb;
   localparam logic [6:0] REMOTE = 7'h5A;
   localparam logic [7:0] RBYTE = 8'hC3;
   logic clk = 1'b0;
   logic resetN = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [7:0] lastByte;
   logic hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, remoteLow, masterAcked, stopSeen;
   int errorCnt = 0;
   int testsRun = 0;
   int cycles = 0;
   wire scl = ~sclOe;
   wire sda = ~(sdaOe | remoteLow);
   always #20 clk = ~clk;
   smbus_transfer_sequencer i_smbus_transfer_sequencer (.clk(clk), .reset_n(resetN),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   smbus_remote_slave #(.ADDR(REMOTE), .READ_BYTE(RBYTE)) i_smbus_remote_slave (.scl(scl),
      .sda(sda), .sdaLow(remoteLow), .lastByte(lastByte), .masterAcked(masterAcked),
      .stopSeen(stopSeen));
   task automatic stopTest;
      if (errorCnt == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stopTest
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      bus(1'b1, a, v, d);
   endtask : wr
   // control write with inhibit set; done bit 0 releases a held bus
   task automatic ctrl(input logic start, input logic stop, input logic ack, input logic hw);
      wr(smbus_seq_pkg::CTRL_ADDR, {26'h0, 2'b01, hw, ack, stop, start});
   endtask : ctrl
   task automatic waitStat(input int pos, input logic val, output logic [31:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, smbus_seq_pkg::STATUS_ADDR, 32'h0, s);
         n++;
      end while (s[pos] !== val && n < 5000);
   endtask : waitStat
   task automatic regReset;
      logic [31:0] v;
      check({sclOe, sdaOe}, 2'b00);
      bus(1'b0, smbus_seq_pkg::DATA_ADDR, 32'h0, v);
      check(v, 32'h0);
      bus(1'b0, smbus_seq_pkg::MASK_ADDR, 32'h0, v);
      check(v, 32'h7F);
      wr(8'h20, 32'hFFFF_FFFF);
      bus(1'b0, 8'h20, 32'h0, v);
      check(v, 32'h0);
      waitStat(0, 1'b0, v);
      check(v, 32'h0);
   endtask : regReset
   task automatic masterWrite;
      logic [31:0] s;
      ctrl(1'b1, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      check(s[3:0], 4'hD);
      wr(smbus_seq_pkg::DATA_ADDR, {24'h0, REMOTE, 1'b0});
      ctrl(1'b0, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      check({s[4:0], lastByte}, {5'h1D, REMOTE, 1'b0});
      check(scl, 1'b0);
      wr(smbus_seq_pkg::DATA_ADDR, 32'hA5);
      ctrl(1'b0, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      check({s[4:0], lastByte}, {5'h1D, 8'hA5});
      ctrl(1'b0, 1'b1, 1'b1, 1'b0);
      waitStat(2, 1'b0, s);
      check(stopSeen, 1'b1);
   endtask : masterWrite
   task automatic masterRead;
      logic [31:0] s;
      logic [31:0] v;
      ctrl(1'b1, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      wr(smbus_seq_pkg::DATA_ADDR, {24'h0, REMOTE, 1'b1});
      ctrl(1'b0, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      check(s[4:0], 5'h1D);
      ctrl(1'b0, 1'b0, 1'b1, 1'b0);
      waitStat(0, 1'b1, s);
      bus(1'b0, smbus_seq_pkg::DATA_ADDR, 32'h0, v);
      check({s[3:0], sdaOe, v[7:0]}, {4'h7, 1'b0, RBYTE});
      ctrl(1'b0, 1'b0, 1'b1, 1'b1);
      waitStat(0, 1'b1, s);
      check({s[1], masterAcked}, 2'b01);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      waitStat(0, 1'b1, s);
      check({s[1], masterAcked}, 2'b00);
      ctrl(1'b0, 1'b1, 1'b0, 1'b1);
      waitStat(2, 1'b0, s);
      check(stopSeen, 1'b1);
   endtask : masterRead
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errorCnt++;
         stopTest();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      resetN <= 1'b1;
      @(posedge clk);
      regReset();
      masterWrite();
      masterRead();
      stopTest();
   end
endmodule : tb
